// *** inc/sdram_timing_pkg.sv ***
/*
  shared constants, carriers and helpers for the two-bank sdram command and timing core.
  assumes a single 20 mhz device clock and cycle counts fixed by the speed table.
*/
`default_nettype none

package sdram_timing_pkg;

  // clock
  localparam int CLK_MHZ = 20;

  // geometry
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 12;
  localparam int ROW_W   = 11;
  localparam int COL_W   = 8;
  localparam int BANKS   = 2;
  localparam int FIFO_DEPTH = 8;

  // controller-side spacing, in cycles, for the bench
  localparam int MODE_LOAD_SETTLE_TIME_CYC = 2;
  localparam int ACT_TO_COL_CYC            = 3;
  localparam int ACT_TO_ACT_SAME_CYC       = 10;
  localparam int ACT_TO_CLOSE_MIN_CYC      = 6;
  localparam int CLOSE_TO_ACT_CYC          = 3;
  localparam int ACT_TO_ACT_OTHER_CYC      = 2;
  localparam int COL_TO_COL_CYC            = 1;
  localparam int WRITE_TO_CLOSE_CYC        = 2;
  localparam int WRITE_AUTOCLOSE_TO_ACTIVATE_DELAY_CYC = 5;
  localparam int ACT_TO_CLOSE_MAX_NS       = 100000;
  localparam int ACT_TO_CLOSE_MAX_CYC      = (ACT_TO_CLOSE_MAX_NS * CLK_MHZ) / 1000;
  localparam int POWERUP_WAIT_US           = 100;
  localparam int POWERUP_WAIT_CYC          = POWERUP_WAIT_US * CLK_MHZ;
  localparam int WAKE_EXTRA_NS             = 3;
  localparam int WAKE_CYC = 1 + (WAKE_EXTRA_NS * CLK_MHZ + 999) / 1000;

  // device-side latencies, in cycles
  localparam int CAS_LATENCY_CYC             = 3;
  localparam int STOP_TO_OUTPUT_FLOAT_DELAY  = 3;
  localparam int STOP_TO_WRITE_IGNORE_DELAY  = 0;
  localparam int CLOSE_TO_OUTPUT_FLOAT_DELAY = 3;
  localparam int MASK_TO_OUTPUT_DELAY        = 2;
  localparam int MASK_TO_INPUT_DELAY         = 0;
  localparam int LAST_OUT_TO_AUTOCLOSE_TIME  = -2;

  // auto-close countdown loads, in ticks after the last beat
  localparam logic [1:0] AUTOCLOSE_READ_LOAD  = 2'h1;
  localparam logic [1:0] AUTOCLOSE_WRITE_LOAD = 2'h2;
  localparam logic [1:0] AUTOCLOSE_FIRE       = 2'h1;

  // mode word fields
  localparam int MODE_LEN_LSB     = 0;
  localparam int MODE_WRAP_BIT    = 3;
  localparam int MODE_SINGLE_WR_BIT = 9;
  localparam logic [2:0] MODE_LEN_FULL = 3'h7;

  // reset values
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  localparam logic [ROW_W-1:0]  REFRESH_ROW_RESET = 11'h000;
  localparam logic              CKE_PREV_RESET = 1'b0;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  typedef struct packed {
    logic             bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } mem_addr_t;

  typedef struct packed {
    mem_addr_t         addr;
    logic [1:0]        be;
    logic [DATA_W-1:0] data;
  } wr_word_t;

  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} burst_state_t;

  function automatic logic [1:0] bank_onehot(input logic bank);
    bank_onehot = bank ? 2'b10 : 2'b01;
  endfunction : bank_onehot

  function automatic logic [COL_W-1:0] burst_len_m1(input logic [2:0] code);
    case (code)
      3'h0:    burst_len_m1 = 8'h00;
      3'h1:    burst_len_m1 = 8'h01;
      3'h2:    burst_len_m1 = 8'h03;
      3'h3:    burst_len_m1 = 8'h07;
      3'h7:    burst_len_m1 = 8'hff;
      default: burst_len_m1 = 8'h00;
    endcase
  endfunction : burst_len_m1

  // wraps inside the burst window; len_m1 doubles as the window mask
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
                                                 input logic [COL_W-1:0] cnt,
                                                 input logic [COL_W-1:0] len_m1,
                                                 input logic             interleave);
    logic [COL_W-1:0] off;
    off = interleave ? (base ^ cnt) : COL_W'(base + cnt);
    burst_col = (base & ~len_m1) | (off & len_m1);
  endfunction : burst_col

endpackage : sdram_timing_pkg

`default_nettype wire

// *** core/sdram_bank_state.sv ***
/*
  one bank's open flag and open row.
  assumes activate and close pulses are already qualified by the command decoder.
*/
`timescale 1ns/1ns
`default_nettype none

module sdram_bank_state (
  // clock and reset
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_n_in,
  // events
  input  wire logic                            act_in,
  input  wire logic                            close_in,
  input  wire logic [sdram_timing_pkg::ROW_W-1:0] row_in,
  // state
  output logic                                 open_out,
  output logic [sdram_timing_pkg::ROW_W-1:0]   row_out
);

  logic                             open_reg;
  logic [sdram_timing_pkg::ROW_W-1:0] row_reg;

  // a close in the same cycle as an activate loses; the activate is newer
  wire open_next = act_in | (open_reg & ~close_in);

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      open_reg <= 1'b0;
      row_reg  <= sdram_timing_pkg::REFRESH_ROW_RESET;
    end
    else
    begin
      open_reg <= open_next;
      if (act_in)
      begin
        row_reg <= row_in;
      end
    end
  end

  assign open_out = open_reg;
  assign row_out  = row_reg;

endmodule : sdram_bank_state

`default_nettype wire

// *** core/sdram_sync_fifo.sv ***
/*
  synchronous fifo with valid and ready on both sides.
  assumes one clock; depth must be a power of two.
*/
`timescale 1ns/1ns
`default_nettype none

module sdram_sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  wire empty   = (wr_ptr_reg == rd_ptr_reg);
  wire full    = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire push    = in_valid_in & ~full;
  wire pop     = out_ready_in & ~empty;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      store[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = store[rd_ptr_reg[AW-1:0]];

endmodule : sdram_sync_fifo

`default_nettype wire

// *** core/sdram_command_timing.sv ***
/*
  command decoder, bank tracking, burst engine and data pipelines of a two-bank sdram.
  assumes a controller that samples pins on the rising edge of clk_sys_in and keeps
  its own command spacing; commands count only when cke was high the cycle before.
*/
// Operation
// - mode load captures all twelve address pins into the mode word.
// - activate opens the row on address bits 10..0 in the selected bank.
// - a new column command is accepted every cycle.
// - burst stop in a read floats the outputs 3 cycles later.
// - burst stop in a write drops write data from that same cycle.
// - close during a read floats the outputs 3 cycles later.
// - close during a write drops write data from that same cycle.
// - read auto-close starts 2 cycles before the last data word leaves.
// - read byte mask disables the output byte 2 cycles after sampling.
// - write byte mask blocks the input byte in the same cycle.
// - read data appears with a latency of 3 cycles.
// - close with the scope bit high closes both banks, else the selected one.
`timescale 1ns/1ns
`default_nettype none

module sdram_command_timing (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // command pins
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [1:0]  dqm_in,
  // data pins
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic [1:0]       dq_oe_n_out,
  // status
  output logic             write_ready_out,
  output logic [1:0]       bank_open_out,
  output logic [11:0]      mode_word_out,
  output logic [10:0]      refresh_row_out,
  output logic             cmd_violation_out
);

  typedef sdram_timing_pkg::cmd_pins_t    cmd_pins_t;
  typedef sdram_timing_pkg::mem_addr_t    mem_addr_t;
  typedef sdram_timing_pkg::wr_word_t     wr_word_t;
  typedef sdram_timing_pkg::burst_state_t burst_state_t;

  // command decode
  logic      cke_prev_reg;
  cmd_pins_t pins;
  assign pins = '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in, we_n: we_n_in};

  // clock suspend freezes decode, burst engine and read pipeline; the write buffer keeps draining
  wire tick   = cke_prev_reg;
  wire sel    = tick & ~pins.cs_n;
  wire is_mrs = sel & ~pins.ras_n & ~pins.cas_n & ~pins.we_n;
  wire is_ref = sel & ~pins.ras_n & ~pins.cas_n &  pins.we_n;
  wire is_pre = sel & ~pins.ras_n &  pins.cas_n & ~pins.we_n;
  wire is_act = sel & ~pins.ras_n &  pins.cas_n &  pins.we_n;
  wire is_wr  = sel &  pins.ras_n & ~pins.cas_n & ~pins.we_n;
  wire is_rd  = sel &  pins.ras_n & ~pins.cas_n &  pins.we_n;
  wire is_bst = sel &  pins.ras_n &  pins.cas_n & ~pins.we_n;

  wire bank_select_pin     = addr_in[11];
  wire precharge_scope_bit = addr_in[10];
  wire [1:0] sel_onehot    = sdram_timing_pkg::bank_onehot(bank_select_pin);

  // banks
  logic [1:0]  bank_open;
  logic [10:0] bank_row [0:1];
  logic [1:0]  ap_close;

  wire [1:0] act_hit   = {2{is_act}} & sel_onehot;
  wire [1:0] pre_close = {2{is_pre}} & (precharge_scope_bit ? 2'b11 : sel_onehot);

  genvar g;
  generate
    for (g = 0; g < sdram_timing_pkg::BANKS; g++)
    begin : gen_bank
      sdram_bank_state u_bank (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .act_in     (act_hit[g]),
        .close_in   (pre_close[g] | ap_close[g]),
        .row_in     (addr_in[10:0]),
        .open_out   (bank_open[g]),
        .row_out    (bank_row[g])
      );
    end
  endgenerate

  // mode word and refresh row
  logic [11:0] mode_reg;
  logic [10:0] refresh_row_reg;
  logic        violation_reg;

  wire [2:0] len_code   = mode_reg[sdram_timing_pkg::MODE_LEN_LSB +: 3];
  wire       full_page  = (len_code == sdram_timing_pkg::MODE_LEN_FULL);
  wire       interleave = mode_reg[sdram_timing_pkg::MODE_WRAP_BIT];
  wire       single_wr  = mode_reg[sdram_timing_pkg::MODE_SINGLE_WR_BIT];
  wire [7:0] mode_len_m1 = sdram_timing_pkg::burst_len_m1(len_code);

  // column to an idle bank is dropped and flagged
  wire col_req = is_rd | is_wr;
  wire col_cmd = col_req & bank_open[bank_select_pin];
  wire violation_next = (col_req & ~col_cmd) | (is_mrs & (|bank_open));

  // burst engine
  burst_state_t state_reg;
  burst_state_t state_next;
  logic [7:0]   base_reg;
  logic [7:0]   base_next;
  logic [7:0]   cnt_reg;
  logic [7:0]   cnt_next;
  logic [7:0]   len_reg;
  logic [7:0]   len_next;
  logic         bank_reg;
  logic         bank_next;
  logic         ap_reg;
  logic         ap_next;

  wire busy       = (state_reg != sdram_timing_pkg::BURST_IDLE);
  wire pre_hits   = is_pre & (precharge_scope_bit | (bank_select_pin == bank_reg));
  wire interrupt  = busy & (is_bst | pre_hits);
  wire beat_valid = col_cmd | (tick & busy & ~interrupt);
  wire beat_read  = col_cmd ? is_rd : (state_reg == sdram_timing_pkg::BURST_READ);
  wire beat_bank  = col_cmd ? bank_select_pin : bank_reg;
  wire [7:0] beat_cnt  = col_cmd ? 8'h00 : cnt_reg;
  wire [7:0] beat_base = col_cmd ? addr_in[7:0] : base_reg;
  wire [7:0] wr_len    = single_wr ? 8'h00 : mode_len_m1;
  wire [7:0] beat_len  = col_cmd ? (is_wr ? wr_len : mode_len_m1) : len_reg;
  wire beat_full  = full_page & ~(col_cmd & is_wr & single_wr);
  wire beat_last  = (beat_cnt == beat_len) & ~beat_full;
  wire beat_ap    = col_cmd ? precharge_scope_bit : ap_reg;
  wire rd_beat    = beat_valid & beat_read;
  wire wr_beat    = beat_valid & ~beat_read;

  mem_addr_t beat_addr;
  assign beat_addr = '{bank: beat_bank,
                       row:  bank_row[beat_bank],
                       col:  sdram_timing_pkg::burst_col(beat_base, beat_cnt, beat_len,
                                                         interleave)};

  always_comb
  begin
    state_next = state_reg;
    base_next  = base_reg;
    cnt_next   = cnt_reg;
    len_next   = len_reg;
    bank_next  = bank_reg;
    ap_next    = ap_reg;
    if (col_cmd)
    begin
      base_next = addr_in[7:0];
      cnt_next  = 8'h01;
      len_next  = beat_len;
      bank_next = bank_select_pin;
      ap_next   = precharge_scope_bit;
      if (beat_last)
      begin
        state_next = sdram_timing_pkg::BURST_IDLE;
      end
      else
      begin
        state_next = is_rd ? sdram_timing_pkg::BURST_READ : sdram_timing_pkg::BURST_WRITE;
      end
    end
    else if (interrupt)
    begin
      state_next = sdram_timing_pkg::BURST_IDLE;
    end
    else if (beat_valid)
    begin
      if (beat_last)
      begin
        state_next = sdram_timing_pkg::BURST_IDLE;
      end
      cnt_next = cnt_reg + 8'h01;
    end
  end

  // auto-close countdown; an interrupted burst never auto-closes
  logic [1:0] ap_cnt_reg;
  logic       ap_bank_reg;
  wire ap_fire    = beat_valid & beat_last & beat_ap;
  wire ap_due     = tick & (ap_cnt_reg == sdram_timing_pkg::AUTOCLOSE_FIRE);
  // read: close one tick after the last beat, two ticks before its data leaves
  wire [1:0] ap_load = beat_read ? sdram_timing_pkg::AUTOCLOSE_READ_LOAD
                                 : sdram_timing_pkg::AUTOCLOSE_WRITE_LOAD;
  wire [1:0] ap_cnt_next = ap_fire ? ap_load :
                           ((tick & (ap_cnt_reg != 2'h0)) ? ap_cnt_reg - 2'h1 : ap_cnt_reg);
  assign ap_close = {2{ap_due}} & sdram_timing_pkg::bank_onehot(ap_bank_reg);

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cke_prev_reg    <= sdram_timing_pkg::CKE_PREV_RESET;
      mode_reg        <= sdram_timing_pkg::MODE_RESET;
      refresh_row_reg <= sdram_timing_pkg::REFRESH_ROW_RESET;
      violation_reg   <= 1'b0;
      state_reg       <= sdram_timing_pkg::BURST_IDLE;
      base_reg        <= 8'h00;
      cnt_reg         <= 8'h00;
      len_reg         <= 8'h00;
      bank_reg        <= 1'b0;
      ap_reg          <= 1'b0;
      ap_cnt_reg      <= 2'h0;
      ap_bank_reg     <= 1'b0;
    end
    else
    begin
      cke_prev_reg  <= cke_in;
      violation_reg <= violation_next;
      if (is_mrs)
      begin
        mode_reg <= addr_in;
      end
      if (is_ref)
      begin
        refresh_row_reg <= refresh_row_reg + 11'h001;
      end
      state_reg   <= state_next;
      base_reg    <= base_next;
      cnt_reg     <= cnt_next;
      len_reg     <= len_next;
      bank_reg    <= bank_next;
      ap_reg      <= ap_next;
      ap_cnt_reg  <= ap_cnt_next;
      if (ap_fire)
      begin
        ap_bank_reg <= beat_bank;
      end
    end
  end

  // write path: masked bytes enter the buffer with their enables and are skipped at drain
  wr_word_t wr_word;
  wr_word_t drain_word;
  logic     fifo_ready;
  logic     drain_valid;
  assign wr_word = '{addr: beat_addr, be: ~dqm_in, data: dq_in};

  // single memory port: reads win, so buffered writes wait through read beats
  wire drain_ready = ~rd_beat;
  wire drain_fire  = drain_valid & drain_ready;

  sdram_sync_fifo #(
    .WIDTH ($bits(wr_word_t)),
    .DEPTH (sdram_timing_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_beat),
    .in_ready_out  (fifo_ready),
    .in_data_in    (wr_word),
    .out_valid_out (drain_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_word)
  );

  // storage array; a read that overtakes a buffered write to the same word sees old data
  logic [15:0] mem [0:(1 << $bits(mem_addr_t)) - 1];
  logic [15:0] mem_q_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (rd_beat)
    begin
      mem_q_reg <= mem[beat_addr];
    end
    if (drain_fire & drain_word.be[0])
    begin
      mem[drain_word.addr][7:0] <= drain_word.data[7:0];
    end
    if (drain_fire & drain_word.be[1])
    begin
      mem[drain_word.addr][15:8] <= drain_word.data[15:8];
    end
  end

  // read pipeline: beat edge, stage edge, pin edge, sampled on the next
  logic        rd_v1_reg;
  logic        rd_v2_reg;
  logic [15:0] rd_d2_reg;
  logic [1:0]  dqm_d_reg;
  logic [15:0] dq_out_reg;
  logic [1:0]  oe_n_reg;

  wire [1:0] oe_n_next = ~({2{rd_v2_reg}} & ~dqm_d_reg);

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rd_v1_reg  <= 1'b0;
      rd_v2_reg  <= 1'b0;
      rd_d2_reg  <= 16'h0000;
      dqm_d_reg  <= 2'h3;
      dq_out_reg <= 16'h0000;
      oe_n_reg   <= 2'h3;
    end
    else if (tick)
    begin
      rd_v1_reg  <= rd_beat;
      rd_v2_reg  <= rd_v1_reg;
      rd_d2_reg  <= mem_q_reg;
      dqm_d_reg  <= dqm_in;
      dq_out_reg <= rd_d2_reg;
      oe_n_reg   <= oe_n_next;
    end
  end

  assign dq_out            = dq_out_reg;
  assign dq_oe_n_out       = oe_n_reg;
  assign write_ready_out   = fifo_ready;
  assign bank_open_out     = bank_open;
  assign mode_word_out     = mode_reg;
  assign refresh_row_out   = refresh_row_reg;
  assign cmd_violation_out = violation_reg;

endmodule : sdram_command_timing

`default_nettype wire

// *** test/sdram_command_timing_chk.sv ***
/*
  concurrent checks on the sdram command and timing core, bound to its ports.
  assumes all pins are sampled on the rising edge of clk_sys_in.
*/
`timescale 1ns/1ns
`default_nettype none

module sdram_command_timing_chk (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // command pins
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [1:0]  dqm_in,
  // data and status
  input  wire logic [15:0] dq_in,
  input  wire logic [15:0] dq_out,
  input  wire logic [1:0]  dq_oe_n_out,
  input  wire logic        write_ready_out,
  input  wire logic [1:0]  bank_open_out,
  input  wire logic [11:0] mode_word_out,
  input  wire logic [10:0] refresh_row_out,
  input  wire logic        cmd_violation_out
);
  logic            cke_reg;
  wire logic [2:0] op  = {ras_n_in, cas_n_in, we_n_in};
  wire logic       go  = cke_reg && !cs_n_in;
  wire logic       mrs = go && op == 3'h0;
  wire logic       pre = go && op == 3'h2;
  wire logic       act = go && op == 3'h3;
  wire logic       rd  = go && op == 3'h5 && bank_open_out[addr_in[11]];
  wire logic       bst = go && op == 3'h6;
  // commands count only with cke high the edge before
  always_ff @(posedge clk_sys_in) cke_reg <= rst_n_in && cke_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_mode_capture: assert property (mrs |=> mode_word_out == $past(addr_in))
    else $error("mode word not captured");
  a_act_opens: assert property (act |=> bank_open_out[$past(addr_in[11])])
    else $error("activate did not open bank");
  a_scope_all: assert property (pre && addr_in[10] |=> bank_open_out == 2'b00)
    else $error("close all left a bank open");
  a_read_latency: assert property ((rd && cke_in) ##1 (cke_in && dqm_in == 2'b00) ##1 cke_in
    |=> dq_oe_n_out == 2'b00) else $error("read word missing at latency three");
  a_read_mask: assert property ((cke_reg && cke_in && dqm_in[1]) ##1 cke_in
    |=> dq_oe_n_out[1]) else $error("masked byte still driven");
  a_stop_float: assert property ((bst && cke_in) ##1 cke_in ##1 cke_in
    |=> dq_oe_n_out == 2'b11) else $error("outputs driven after burst stop");
  a_close_float: assert property ((pre && addr_in[10] && cke_in) ##1 cke_in ##1 cke_in
    |=> dq_oe_n_out == 2'b11) else $error("outputs driven after close");
  a_auto_close: assert property ((rd && addr_in[10:9] == 2'b10 && !addr_in[11]
    && mode_word_out[2:0] == 3'h0 && cke_in) ##1 !(act && !addr_in[11])
    |=> !bank_open_out[0]) else $error("read auto close late");
endmodule : sdram_command_timing_chk

bind sdram_command_timing sdram_command_timing_chk i_chk (.clk_sys_in, .rst_n_in, .cke_in,
  .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .addr_in, .dqm_in, .dq_in, .dq_out,
  .dq_oe_n_out, .write_ready_out, .bank_open_out, .mode_word_out, .refresh_row_out,
  .cmd_violation_out);

`default_nettype wire

// *** test/sdram_ctrl_model.sv ***
/*
  behavioural memory controller that spaces commands on the sdram pins.
  assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module sdram_ctrl_model (
  // clock
  input  wire logic   clk_sys_in,
  // pins toward the device
  output logic        cke_out,
  output logic        cs_n_out,
  output logic [2:0]  rcw_n_out,
  output logic [11:0] addr_out,
  output logic [1:0]  dqm_out,
  output logic [15:0] dq_out
);
  int cyc = 0;
  int t_act[2] = '{-99, -99};
  int t_pre[2] = '{-99, -99};
  int t_wr[2] = '{-99, -99};
  int t_mrs = -99;
  int t_ref = -99;
  int t_aa = -99;
  int t_wa = -99;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  // cke never drops, so no wake-up wait is owed
  initial
  begin
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    rcw_n_out = 3'h7;
    addr_out = 12'h000;
    dqm_out = 2'h0;
    dq_out = 16'h0000;
  end
  function automatic int mx(input int a, input int b);
    mx = (a > b) ? a : b;
  endfunction : mx
  // released data lines toggle so no stale word looks valid
  task automatic nop();
    cs_n_out <= 1'b0;
    rcw_n_out <= 3'h7;
    dqm_out <= 2'h0;
    dq_out <= ~dq_out;
    @(posedge clk_sys_in);
  endtask : nop
  task automatic issue(input logic [2:0] op, input logic [11:0] a, input logic [1:0] m,
                       input logic [15:0] d);
    int   e;
    logic b;
    b = a[11];
    e = mx(sdram_timing_pkg::POWERUP_WAIT_CYC, t_mrs + 2);
    case (op)
      3'h0: e = mx(e, mx(t_pre[0], t_pre[1]) + 3);
      3'h1: e = mx(e, mx(t_ref + 10, mx(t_pre[0], t_pre[1]) + 3));
      3'h2: e = mx(e, mx(t_act[b] + 6, t_wr[b] + 2));
      3'h3: e = mx(mx(e, t_act[b] + 10), mx(t_pre[b] + 3, t_aa + 2));
      default: e = mx(e, t_act[b] + 3);
    endcase
    if (op == 3'h1 || op == 3'h3) e = mx(e, t_wa + 5);
    while (cyc < e)
      nop();
    cs_n_out <= 1'b0;
    rcw_n_out <= op;
    addr_out <= a;
    dqm_out <= m;
    dq_out <= d;
    if (op == 3'h3) t_act[b] = cyc;
    if (op == 3'h3) t_aa = cyc;
    if (op == 3'h2) t_pre[b] = cyc;
    if (op == 3'h2 && a[10]) t_pre[!b] = cyc;
    if (op == 3'h0) t_mrs = cyc;
    if (op == 3'h1) t_ref = cyc;
    if (op == 3'h4) t_wr[b] = cyc;
    if (op == 3'h4 && a[10]) t_wa = cyc;
    @(posedge clk_sys_in);
  endtask : issue
endmodule : sdram_ctrl_model

`default_nettype wire

// *** test/tb_sdram_command_timing.sv ***
/*
  self-checking bench for the sdram command and timing core.
  assumes the controller model keeps all command spacing.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_sdram_command_timing;
  logic        clk_sys_in, rst_n_in, cke, cs_n, wr_rdy, watch, viol;
  logic [2:0]  rcw_n;
  logic [11:0] addr, mode_word;
  logic [1:0]  dqm, oe_n, bank_open;
  logic [15:0] dq_wr, dq_rd;
  logic [10:0] ref_row;
  logic [15:0] mem[4];
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h108fa4f8;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  sdram_ctrl_model i_ctl (.clk_sys_in, .cke_out(cke), .cs_n_out(cs_n), .rcw_n_out(rcw_n),
    .addr_out(addr), .dqm_out(dqm), .dq_out(dq_wr));
  sdram_command_timing i_dut (.clk_sys_in, .rst_n_in, .cke_in(cke), .cs_n_in(cs_n),
    .ras_n_in(rcw_n[2]), .cas_n_in(rcw_n[1]), .we_n_in(rcw_n[0]), .addr_in(addr),
    .dqm_in(dqm), .dq_in(dq_wr), .dq_out(dq_rd), .dq_oe_n_out(oe_n),
    .write_ready_out(wr_rdy), .bank_open_out(bank_open), .mode_word_out(mode_word),
    .refresh_row_out(ref_row), .cmd_violation_out(viol));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // power-up wait dominates the run, so the ceiling sits well above it
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(posedge clk_sys_in)
    if (watch && oe_n !== 2'b11)
      check("read_word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, dq_rd);
  initial
  begin
    logic [11:0] mw;
    logic [1:0]  m;
    rst_n_in = 1'b0;
    watch = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    check("reset_state", 16'h0000, {2'h0, bank_open, mode_word});
    check("reset_oe", 16'h0003, 16'(oe_n));
    seed = xs(seed);
    mw = {seed[11:3], 3'h7};
    i_ctl.issue(3'h0, mw, 2'h0, 16'h0000);
    i_ctl.nop();
    check("mode_word", 16'(mw), 16'(mode_word));
    seed = xs(seed);
    i_ctl.issue(3'h3, {1'b0, seed[10:0]}, 2'h0, 16'h0000);
    i_ctl.issue(3'h3, {1'b1, seed[21:11]}, 2'h0, 16'h0000);
    i_ctl.nop();
    check("bank_open", 16'h0003, 16'(bank_open));
    $display("mode and activate test done");
    i_ctl.issue(3'h5, 12'h000, 2'h0, 16'h0000);
    i_ctl.nop();
    i_ctl.issue(3'h6, 12'h000, 2'h2, 16'h0000);
    repeat (4) i_ctl.nop();
    i_ctl.issue(3'h5, 12'h010, 2'h0, 16'h0000);
    i_ctl.issue(3'h2, 12'h800, 2'h0, 16'h0000);
    i_ctl.nop();
    check("close_one", 16'h0001, 16'(bank_open));
    i_ctl.issue(3'h2, 12'h400, 2'h0, 16'h0000);
    repeat (4) i_ctl.nop();
    check("close_all", 16'h0000, 16'(bank_open));
    i_ctl.issue(3'h5, 12'h000, 2'h0, 16'h0000);
    i_ctl.nop();
    check("violation", 16'h0001, 16'(viol));
    i_ctl.nop();
    check("violation", 16'h0000, 16'(viol));
    $display("stop and close test done");
    i_ctl.issue(3'h0, 12'h000, 2'h0, 16'h0000);
    i_ctl.issue(3'h3, 12'h000, 2'h0, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      mem[k] = seed[15:0];
      i_ctl.issue(3'h4, 12'(k), 2'h0, mem[k]);
    end
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      m = seed[17:16];
      i_ctl.issue(3'h4, 12'(k), m, seed[15:0]);
      mem[k] = {m[1] ? mem[k][15:8] : seed[15:8], m[0] ? mem[k][7:0] : seed[7:0]};
    end
    repeat (12) i_ctl.nop();
    check("write_ready", 16'h0001, 16'(wr_rdy));
    watch = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      exp_q.push_back(mem[k]);
      i_ctl.issue(3'h5, {1'b0, k == 3, 2'h0, 8'(k)}, 2'h0, 16'h0000);
    end
    repeat (6) i_ctl.nop();
    watch = 1'b0;
    check("reads_left", 16'h0000, 16'(exp_q.size()));
    check("auto_close", 16'h0000, 16'(bank_open));
    $display("write and read test done");
    i_ctl.issue(3'h2, 12'h400, 2'h0, 16'h0000);
    i_ctl.issue(3'h1, 12'h000, 2'h0, 16'h0000);
    i_ctl.issue(3'h1, 12'h000, 2'h0, 16'h0000);
    i_ctl.nop();
    check("refresh_row", 16'h0002, 16'(ref_row));
    $display("refresh test done");
    complete_run();
  end
endmodule : tb_sdram_command_timing

`default_nettype wire
